/* pbsi_pkg.sv */
package pbsi_pkg;

  // ----------------------------------------------------------------
  // bus commands and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] PBSI_CMD_MEM_RD = 4'h6;
  localparam logic [3:0] PBSI_CMD_MEM_WR = 4'h7;
  // cycles a master waits for a claim before giving up
  localparam logic [2:0] PBSI_DEVSEL_WAIT = 3'h5;
  // pin synchroniser depth
  localparam int PBSI_SYNC_STAGES = 3;
  // default target window
  localparam logic [31:0] PBSI_TGT_BASE = 32'h8000_0000;
  localparam logic [31:0] PBSI_TGT_MASK = 32'hF000_0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] cmd;
    logic write;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } pbsi_mreq_t;

  typedef struct packed {
    logic [31:0] data;
    logic abort;
  } pbsi_mrsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] be;
  } pbsi_twr_t;

  typedef enum logic [2:0] {
    PBSI_M_IDLE = 3'b000,
    PBSI_M_REQ = 3'b001,
    PBSI_M_ADDR = 3'b010,
    PBSI_M_DATA = 3'b011,
    PBSI_M_TURN = 3'b100
  } pbsi_mstate_t;

  typedef enum logic [2:0] {
    PBSI_T_IDLE = 3'b000,
    PBSI_T_CLAIM = 3'b001,
    PBSI_T_DATA = 3'b010,
    PBSI_T_STOP = 3'b011,
    PBSI_T_DONE = 3'b100
  } pbsi_tstate_t;

endpackage

/* pbsi_pci_side.sv */
// Functional notes
// - ad bits 7:0 hold the low byte, 31:24 the high byte
// - cbe carries command in address phase, active-low lane enables after
// - driven parity is high when the 36 ad and cbe bits hold odd ones
// - devsel is asserted only after our own address decode hits
// - a foreign devsel during decode means we do not claim
// - frame is asserted to start each transaction we master
// - a foreign frame start is decoded as a possible target access
// - request line is asserted while a queued transaction needs the bus
// - master irdy: write with valid data driven, read when able to take
// - target trdy: read with valid data driven, write when sink ready
// - target asserts stop to retry or disconnect the master
// - a stop seen as master ends our transaction, retried later
// - flush request drains all work, blocks the cpu, then acknowledges
// - isa_bus_master_request request is synchronised and passed on as a level
// - lock held during a claimed access marks memory as locked
// - emulation mode: unlogged target write raises modified memory irq
// - address parity error on a decoded address pulses system error
// - foreign system error is reported as a pulse
// - foreign parity error is reported as a pulse
// - all bus pins are sampled and driven on the system clock
module pbsi_pci_side #(
  parameter logic [31:0] TGT_BASE = pbsi_pkg::PBSI_TGT_BASE,
  parameter logic [31:0] TGT_MASK = pbsi_pkg::PBSI_TGT_MASK,
  parameter int BUF_DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  // user master requests
  input wire logic mreq_valid_i,
  input wire pbsi_pkg::pbsi_mreq_t mreq_i,
  output logic mreq_ready_o,
  output logic mrsp_valid_o,
  output pbsi_pkg::pbsi_mrsp_t mrsp_o,
  // user target side
  output logic twr_valid_o,
  output pbsi_pkg::pbsi_twr_t twr_o,
  input wire logic twr_ready_i,
  output logic trd_req_o,
  output logic [31:0] trd_addr_o,
  input wire logic trd_valid_i,
  input wire logic [31:0] trd_data_i,
  // sideband and status
  input wire logic flush_request_in_i,
  output logic flush_done_ack_o,
  output logic cpu_block_o,
  input wire logic isa_bus_master_request_i,
  output logic isa_mem_req_o,
  output logic mem_locked_o,
  input wire logic emulation_mode_i,
  input wire logic write_logged_i,
  input wire logic irq_clear_i,
  output logic modified_memory_irq_o,
  output logic data_perr_o,
  output logic foreign_serr_o,
  output logic foreign_perr_o,
  // pci pins
  input wire logic [31:0] ad_i,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  input wire logic [3:0] cbe_n_i,
  output logic [3:0] cbe_n_o,
  output logic cbe_oe_o,
  input wire logic par_i,
  output logic par_o,
  output logic par_oe_o,
  input wire logic frame_n_i,
  output logic frame_n_o,
  output logic frame_oe_o,
  input wire logic irdy_n_i,
  output logic irdy_n_o,
  output logic irdy_oe_o,
  input wire logic trdy_n_i,
  output logic trdy_n_o,
  output logic trdy_oe_o,
  input wire logic stop_n_i,
  output logic stop_n_o,
  output logic stop_oe_o,
  input wire logic devsel_n_i,
  output logic devsel_n_o,
  output logic devsel_oe_o,
  input wire logic perr_n_i,
  output logic perr_n_o,
  output logic perr_oe_o,
  input wire logic serr_n_i,
  output logic serr_n_o,
  output logic serr_oe_o,
  output logic req_n_o,
  input wire logic gnt_n_i,
  input wire logic lock_n_i
);
  import pbsi_pkg::*;

  // ----------------------------------------------------------------
  // sideband synchronisers
  // ----------------------------------------------------------------
  logic [PBSI_SYNC_STAGES-1:0] flush_sh_q, isa_sh_q;
  logic flush_q, isa_q;

  // first stage feeds only the second; a change counts once 2 and 3 agree
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flush_sh_q <= '0;
      isa_sh_q <= '0;
      flush_q <= 1'b0;
      isa_q <= 1'b0;
    end else begin
      flush_sh_q <= {flush_sh_q[1:0], flush_request_in_i};
      isa_sh_q <= {isa_sh_q[1:0], isa_bus_master_request_i};
      if (flush_sh_q[1] == flush_sh_q[2]) flush_q <= flush_sh_q[2];
      if (isa_sh_q[1] == isa_sh_q[2]) isa_q <= isa_sh_q[2];
    end
  end
  assign isa_mem_req_o = isa_q;

  // ----------------------------------------------------------------
  // two-entry request buffer
  // ----------------------------------------------------------------
  localparam int PW = $clog2(BUF_DEPTH);
  pbsi_mreq_t buf_q [BUF_DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic buf_push, buf_pop, buf_empty;
  pbsi_mreq_t head;

  assign buf_empty = (cnt_q == '0);
  // new work is refused while a flush is under way
  assign mreq_ready_o = (cnt_q != (PW+1)'(BUF_DEPTH)) && !flush_q;
  assign buf_push = mreq_valid_i && mreq_ready_o;
  assign head = buf_q[rp_q];

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (buf_push) wp_q <= (wp_q == PW'(BUF_DEPTH-1)) ? '0 : wp_q + 1'b1;
      if (buf_pop) rp_q <= (rp_q == PW'(BUF_DEPTH-1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(buf_push) - (PW+1)'(buf_pop);
    end
  end

  // storage needs no reset; only the pointers define validity
  always_ff @(posedge sys_clk_i) begin
    if (buf_push) buf_q[wp_q] <= mreq_i;
  end

  // ----------------------------------------------------------------
  // master engine
  // ----------------------------------------------------------------
  pbsi_mstate_t m_q;
  logic [2:0] wait_q;
  logic m_done, m_stop, m_abort;

  assign m_done = (m_q == PBSI_M_DATA) && !trdy_n_i;
  assign m_stop = (m_q == PBSI_M_DATA) && trdy_n_i && !stop_n_i;
  assign m_abort = (m_q == PBSI_M_DATA) && trdy_n_i && stop_n_i &&
                   devsel_n_i && (wait_q == PBSI_DEVSEL_WAIT);
  // a stopped request stays queued and is re-requested
  assign buf_pop = m_done || m_abort;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      m_q <= PBSI_M_IDLE;
      wait_q <= '0;
    end else begin
      case (m_q)
        PBSI_M_IDLE: if (!buf_empty) m_q <= PBSI_M_REQ;
        PBSI_M_REQ: begin
          // own grant and an idle bus before we drive anything
          if (!gnt_n_i && frame_n_i && irdy_n_i) m_q <= PBSI_M_ADDR;
        end
        PBSI_M_ADDR: begin
          wait_q <= '0;
          m_q <= PBSI_M_DATA;
        end
        PBSI_M_DATA: begin
          wait_q <= wait_q + 3'h1;
          if (m_done || m_stop || m_abort) m_q <= PBSI_M_TURN;
        end
        PBSI_M_TURN: m_q <= PBSI_M_IDLE;
        default: m_q <= PBSI_M_IDLE;
      endcase
    end
  end

  // master response words
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mrsp_valid_o <= 1'b0;
      mrsp_o <= '0;
    end else begin
      mrsp_valid_o <= buf_pop;
      if (buf_pop) begin
        mrsp_o.data <= head.write ? 32'h0000_0000 : ad_i;
        mrsp_o.abort <= m_abort;
      end
    end
  end

  assign req_n_o = !(m_q == PBSI_M_REQ);

  // ----------------------------------------------------------------
  // target engine
  // ----------------------------------------------------------------
  pbsi_tstate_t t_q;
  logic frame_prev_q, t_write_q, rd_have_q, lock_q, t_xfer, t_end;
  logic [31:0] t_addr_q, rd_q;
  logic foreign_start, t_hit, t_trdy, t_stop, retry_q;

  // only frames that are not our own are decoded
  assign foreign_start = !frame_n_i && frame_prev_q &&
                         (m_q == PBSI_M_IDLE || m_q == PBSI_M_REQ);
  assign t_hit = ((ad_i & TGT_MASK) == TGT_BASE) &&
                 (~cbe_n_i == ~PBSI_CMD_MEM_RD ||
                  ~cbe_n_i == ~PBSI_CMD_MEM_WR);
  assign t_trdy = (t_q == PBSI_T_DATA) && !retry_q &&
                  (t_write_q ? twr_ready_i : rd_have_q);
  // retry when flushing, disconnect when the master wants a burst
  assign t_stop = (t_q == PBSI_T_STOP) ||
                  ((t_q == PBSI_T_DATA) && (retry_q || !frame_n_i));
  assign t_xfer = t_trdy && !irdy_n_i;
  assign t_end = !irdy_n_i && (t_trdy || t_stop) && frame_n_i;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      t_q <= PBSI_T_IDLE;
      frame_prev_q <= 1'b1;
      t_write_q <= 1'b0;
      t_addr_q <= '0;
      retry_q <= 1'b0;
    end else begin
      frame_prev_q <= frame_n_i;
      case (t_q)
        PBSI_T_IDLE: begin
          if (foreign_start && t_hit) begin
            t_q <= PBSI_T_CLAIM;
            t_addr_q <= ad_i;
            t_write_q <= (cbe_n_i == PBSI_CMD_MEM_WR);
          end
        end
        PBSI_T_CLAIM: begin
          retry_q <= flush_q;
          // someone faster claimed it: stay off the bus
          t_q <= devsel_n_i ? PBSI_T_DATA : PBSI_T_IDLE;
        end
        PBSI_T_DATA: begin
          if (t_end) t_q <= PBSI_T_DONE;
          else if (t_xfer) t_q <= PBSI_T_STOP;
        end
        PBSI_T_STOP: if (t_end) t_q <= PBSI_T_DONE;
        PBSI_T_DONE: t_q <= PBSI_T_IDLE;
        default: t_q <= PBSI_T_IDLE;
      endcase
    end
  end

  // read data fetch and write hand-off
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_have_q <= 1'b0;
      rd_q <= '0;
      twr_valid_o <= 1'b0;
      twr_o <= '0;
    end else begin
      if (t_q == PBSI_T_DONE) rd_have_q <= 1'b0;
      else if (trd_req_o && trd_valid_i) rd_have_q <= 1'b1;
      if (trd_req_o && trd_valid_i) rd_q <= trd_data_i;
      twr_valid_o <= t_xfer && t_write_q;
      if (t_xfer && t_write_q) begin
        twr_o.addr <= t_addr_q;
        twr_o.data <= ad_i;
        twr_o.be <= ~cbe_n_i;
      end
    end
  end
  assign trd_req_o = (t_q == PBSI_T_DATA) && !t_write_q && !rd_have_q &&
                     !retry_q;
  assign trd_addr_o = t_addr_q;

  // lock tracking: held from a locked claim until frame and lock free
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) lock_q <= 1'b0;
    else if (t_q == PBSI_T_CLAIM && !lock_n_i) lock_q <= 1'b1;
    else if (frame_n_i && !lock_n_i == 1'b0) lock_q <= 1'b0;
  end
  assign mem_locked_o = lock_q;

  // modified memory interrupt; set beats clear
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) modified_memory_irq_o <= 1'b0;
    else if (t_xfer && t_write_q && emulation_mode_i && !write_logged_i)
      modified_memory_irq_o <= 1'b1;
    else if (irq_clear_i) modified_memory_irq_o <= 1'b0;
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic m_own, t_own;
  assign m_own = (m_q == PBSI_M_ADDR) || (m_q == PBSI_M_DATA);
  assign t_own = (t_q == PBSI_T_DATA) || (t_q == PBSI_T_STOP) ||
                 (t_q == PBSI_T_DONE);

  assign ad_oe_o = (m_q == PBSI_M_ADDR) ||
                   ((m_q == PBSI_M_DATA) && head.write) ||
                   ((t_q == PBSI_T_DATA) && !t_write_q && rd_have_q);
  // low byte sits in bits 7:0 for address and data alike
  assign ad_o = (m_q == PBSI_M_ADDR) ? head.addr :
                (m_q == PBSI_M_DATA) ? head.data : rd_q;
  assign cbe_oe_o = m_own;
  assign cbe_n_o = (m_q == PBSI_M_ADDR) ? head.cmd : ~head.be;
  assign frame_oe_o = m_own;
  assign frame_n_o = !(m_q == PBSI_M_ADDR);
  // single data phase: frame drops as irdy rises
  assign irdy_oe_o = m_own || (m_q == PBSI_M_TURN);
  assign irdy_n_o = !(m_q == PBSI_M_DATA);
  assign devsel_oe_o = t_own;
  assign devsel_n_o = (t_q == PBSI_T_DONE);
  assign trdy_oe_o = t_own;
  assign trdy_n_o = !t_trdy;
  assign stop_oe_o = t_own;
  assign stop_n_o = !t_stop;

  // ----------------------------------------------------------------
  // parity generation and checking
  // ----------------------------------------------------------------
  logic [31:0] ad_s_q;
  logic [3:0] cbe_s_q;
  logic achk_q, dchk_q, par_bad;

  // parity trails its phase by one clock, as the bus expects
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      par_o <= 1'b0;
      par_oe_o <= 1'b0;
      ad_s_q <= '0;
      cbe_s_q <= '0;
      achk_q <= 1'b0;
      dchk_q <= 1'b0;
    end else begin
      // lanes taken from the bus: on a target read the master owns them
      par_o <= ^{ad_o, cbe_n_i};
      par_oe_o <= ad_oe_o;
      ad_s_q <= ad_i;
      cbe_s_q <= cbe_n_i;
      achk_q <= foreign_start && t_hit;
      dchk_q <= (m_done && !head.write) || (t_xfer && t_write_q);
    end
  end
  assign par_bad = (par_i != ^{ad_s_q, cbe_s_q});

  // error pulses driven and observed
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      serr_oe_o <= 1'b0;
      perr_oe_o <= 1'b0;
      data_perr_o <= 1'b0;
      foreign_serr_o <= 1'b0;
      foreign_perr_o <= 1'b0;
    end else begin
      serr_oe_o <= achk_q && par_bad;
      perr_oe_o <= dchk_q && par_bad;
      data_perr_o <= dchk_q && par_bad;
      foreign_serr_o <= !serr_n_i && !serr_oe_o;
      foreign_perr_o <= !perr_n_i && !perr_oe_o;
    end
  end
  assign serr_n_o = 1'b0;
  assign perr_n_o = 1'b0;

  // ----------------------------------------------------------------
  // flush handshake
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) flush_done_ack_o <= 1'b0;
    else if (!flush_q) flush_done_ack_o <= 1'b0;
    else if (buf_empty && m_q == PBSI_M_IDLE && t_q == PBSI_T_IDLE)
      flush_done_ack_o <= 1'b1;
  end
  // cpu stays blocked from request to release of the synchronised flush
  assign cpu_block_o = flush_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_flush_drained;
    buf_empty && m_q == PBSI_M_IDLE && t_q == PBSI_T_IDLE;
  endsequence
  sequence s_granted;
    m_q == PBSI_M_REQ && !gnt_n_i && frame_n_i && irdy_n_i;
  endsequence

  property p_par_gen;
    par_oe_o |-> par_o == $past(^{ad_o, cbe_n_i});
  endproperty
  a_par_gen: assert property (p_par_gen)
    else $error("driven parity wrong");

  property p_req_rise;
    (!buf_empty && m_q == PBSI_M_IDLE) |-> ##1 !req_n_o;
  endproperty
  a_req_rise: assert property (p_req_rise)
    else $error("request not raised");

  property p_frame_after_gnt;
    s_granted |=> !frame_n_o && frame_oe_o ##1 !irdy_n_o && frame_n_o;
  endproperty
  a_frame_after_gnt: assert property (p_frame_after_gnt)
    else $error("frame sequence wrong after grant");

  property p_no_frame_wo_gnt;
    (frame_oe_o && !frame_n_o) |-> $past(!gnt_n_i);
  endproperty
  a_no_frame_wo_gnt: assert property (p_no_frame_wo_gnt)
    else $error("frame driven without grant");

  property p_irdy_write;
    (irdy_oe_o && !irdy_n_o && head.write) |-> ad_oe_o && ad_o == head.data;
  endproperty
  a_irdy_write: assert property (p_irdy_write)
    else $error("irdy on write without data");

  property p_trdy_read;
    (trdy_oe_o && !trdy_n_o && !t_write_q) |-> ad_oe_o && ad_o == rd_q;
  endproperty
  a_trdy_read: assert property (p_trdy_read)
    else $error("trdy on read without data");

  property p_no_claim;
    (t_q == PBSI_T_CLAIM && !devsel_n_i) |=> !devsel_oe_o [*2];
  endproperty
  a_no_claim: assert property (p_no_claim)
    else $error("claimed a foreign access");

  property p_master_stop;
    m_stop |=> m_q == PBSI_M_TURN ##1 m_q == PBSI_M_IDLE ##1 !req_n_o;
  endproperty
  a_master_stop: assert property (p_master_stop)
    else $error("stop not honoured with retry");

  property p_ack_drained;
    $rose(flush_done_ack_o) |-> $past(cpu_block_o && buf_empty &&
      m_q == PBSI_M_IDLE && t_q == PBSI_T_IDLE);
  endproperty
  a_ack_drained: assert property (p_ack_drained)
    else $error("ack before flush request");

  property p_ack_hold;
    (flush_done_ack_o && flush_q) |-> cpu_block_o ##1 flush_done_ack_o;
  endproperty
  a_ack_hold: assert property (p_ack_hold)
    else $error("ack dropped early");

  property p_irq_set;
    (t_xfer && t_write_q && emulation_mode_i && !write_logged_i)
      |=> modified_memory_irq_o;
  endproperty
  a_irq_set: assert property (p_irq_set)
    else $error("modified memory irq missed");

  property p_serr;
    (achk_q && par_bad) |=> serr_oe_o && !serr_n_o;
  endproperty
  a_serr: assert property (p_serr)
    else $error("address parity error not signalled");

endmodule // pbsi_pci_side

/* pbsi_tgt_model.sv */
module pbsi_tgt_model (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic retry_i,
  input wire logic slow_i,
  input wire logic frame_n_i,
  input wire logic irdy_n_i,
  input wire logic [31:0] ad_i,
  input wire logic [3:0] cbe_n_i,
  output logic devsel_n_o,
  output logic trdy_n_o,
  output logic stop_n_o,
  output logic [31:0] ad_o,
  output logic ad_oe_o,
  output logic par_o,
  output logic par_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fr_q, act_q, wr_q, rty_q;
  logic [1:0] cnt_q;
  logic [31:0] mem_q;

  // ------------------------------------------------------------
  // far target: one word, lanes merged, optional wait and retry
  // ------------------------------------------------------------
  // window of the bridge itself is left alone so it never double claims
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {fr_q, devsel_n_o, trdy_n_o, stop_n_o} <= 4'hF;
      {act_q, wr_q, rty_q, ad_oe_o, par_o, par_oe_o} <= 6'h00;
      cnt_q <= 2'h0;
      ad_o <= 32'h0;
      mem_q <= 32'h0;
    end else begin
      fr_q <= frame_n_i;
      par_o <= ^{ad_o, cbe_n_i};
      par_oe_o <= ad_oe_o;
      if (!retry_i) rty_q <= 1'b0;
      if (!act_q) begin
        if (fr_q && !frame_n_i && ad_i[31:28] != 4'h8) begin
          act_q <= 1'b1;
          wr_q <= cbe_n_i[0];
          cnt_q <= slow_i ? 2'h3 : 2'h0;
          devsel_n_o <= 1'b0;
        end
      end else if (!stop_n_o || (!trdy_n_o && !irdy_n_i)) begin
        // single data phase, then hand the bus back
        {act_q, ad_oe_o} <= 2'h0;
        {devsel_n_o, trdy_n_o, stop_n_o} <= 3'h7;
        for (int i = 0; i < 4; i++)
          if (wr_q && !trdy_n_o && !cbe_n_i[i]) mem_q[8*i+:8] <= ad_i[8*i+:8];
      end else if (cnt_q != 2'h0) begin
        cnt_q <= cnt_q - 2'h1;
      end else if (retry_i && !rty_q) begin
        stop_n_o <= 1'b0;
        rty_q <= 1'b1;
      end else if (trdy_n_o) begin
        trdy_n_o <= 1'b0;
        ad_o <= mem_q;
        ad_oe_o <= !wr_q;
      end
    end
  end
endmodule // pbsi_tgt_model

/* pci_bus_side_interface_tb.sv */
module pci_bus_side_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbsi_pkg::*;
  logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, mreq_valid_i = 1'b0;
  pbsi_mreq_t mreq_i = '0;
  logic twr_ready_i = 1'b1, trd_valid_i = 1'b0, gnt_n_i = 1'b1;
  logic [31:0] trd_data_i = 32'h0, junk_q = 32'h0, d1, d2, pad;
  logic flush_request_in_i = 1'b0, isa_bus_master_request_i = 1'b0;
  logic emulation_mode_i = 1'b0, write_logged_i = 1'b0;
  logic irq_clear_i = 1'b0, lock_n_i = 1'b1, retry = 1'b0, slow = 1'b0;
  logic tb_frame_n = 1'b1, tb_irdy_n = 1'b1, tb_oe = 1'b0;
  logic tb_serr_n = 1'b1, tb_perr_n = 1'b1, tb_par = 1'b0, tb_par_oe = 1'b0;
  logic [31:0] tb_ad = 32'h0;
  logic [3:0] tb_cbe_n = 4'hF, pcbe;
  int n_errors = 0, compares = 0, n_fs = 0, n_fp = 0, n_dp = 0;
  pbsi_mrsp_t rq[$];
  pbsi_mreq_t wq[$];
  pbsi_twr_t tq[$];
  logic mreq_ready_o, mrsp_valid_o, twr_valid_o, trd_req_o;
  pbsi_mrsp_t mrsp_o;
  pbsi_twr_t twr_o;
  logic [31:0] trd_addr_o, ad_o, p_ad;
  logic [3:0] cbe_n_o;
  logic flush_done_ack_o, cpu_block_o, isa_mem_req_o, mem_locked_o;
  logic modified_memory_irq_o, data_perr_o, foreign_serr_o, foreign_perr_o;
  logic ad_oe_o, cbe_oe_o, par_o, par_oe_o, frame_n_o, frame_oe_o;
  logic irdy_n_o, irdy_oe_o, trdy_n_o, trdy_oe_o, stop_n_o, stop_oe_o;
  logic devsel_n_o, devsel_oe_o, perr_n_o, perr_oe_o, serr_n_o, serr_oe_o;
  logic req_n_o, p_dev, p_trdy, p_stop, p_ad_oe, p_par, p_par_oe;

  // ------------------------------------------------------------
  // wire levels: released ad, cbe and par float to a changing pattern
  // ------------------------------------------------------------
  wire logic [31:0] ad_i = ad_oe_o ? ad_o : p_ad_oe ? p_ad
    : tb_oe ? tb_ad : junk_q;
  wire logic [3:0] cbe_n_i = cbe_oe_o ? cbe_n_o : tb_oe ? tb_cbe_n
    : junk_q[3:0];
  wire logic par_i = par_oe_o ? par_o : p_par_oe ? p_par
    : tb_par_oe ? tb_par : junk_q[0];
  wire logic frame_n_i = frame_oe_o ? frame_n_o : tb_frame_n;
  wire logic irdy_n_i = irdy_oe_o ? irdy_n_o : tb_irdy_n;
  wire logic trdy_n_i = trdy_oe_o ? trdy_n_o : p_trdy;
  wire logic stop_n_i = stop_oe_o ? stop_n_o : p_stop;
  wire logic devsel_n_i = devsel_oe_o ? devsel_n_o : p_dev;
  wire logic perr_n_i = !perr_oe_o && tb_perr_n;
  wire logic serr_n_i = !serr_oe_o && tb_serr_n;

  pbsi_pci_side dut (.*);
  pbsi_tgt_model far (.sys_clk_i, .sys_rst_i, .retry_i(retry),
    .slow_i(slow), .frame_n_i, .irdy_n_i, .ad_i, .cbe_n_i,
    .devsel_n_o(p_dev), .trdy_n_o(p_trdy), .stop_n_o(p_stop),
    .ad_o(p_ad), .ad_oe_o(p_ad_oe), .par_o(p_par), .par_oe_o(p_par_oe));

  // ------------------------------------------------------------
  // clock, stimulus source, arbiter
  // ------------------------------------------------------------
  always #2.5 sys_clk_i = ~sys_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // grant trails request by a cycle, a lazy arbiter
  always @(posedge sys_clk_i) begin
    gnt_n_i <= req_n_o;
    junk_q <= ~junk_q ^ {31'h0, junk_q[3]};
    // foreign master parity trails its phase by a clock
    tb_par <= ^{tb_ad, tb_cbe_n};
    tb_par_oe <= tb_oe;
  end
  task automatic chk(input string n, input logic [71:0] e, g);
    compares++;
    if (e !== g) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  // valid is left high so back-to-back pushes never glitch it
  task automatic mreq(input logic w, input logic [31:0] a, d,
                      input logic [3:0] be, input pbsi_mrsp_t e);
    mreq_i <= '{w ? PBSI_CMD_MEM_WR : PBSI_CMD_MEM_RD, w, a, d, be};
    mreq_valid_i <= 1'b1;
    do @(negedge sys_clk_i); while (mreq_ready_o !== 1'b1);
    @(posedge sys_clk_i);
    rq.push_back(e);
    wq.push_back(mreq_i);
  endtask
  task automatic drain;
    mreq_valid_i <= 1'b0;
    for (int i = 0; i < 300 && rq.size() != 0; i++) @(posedge sys_clk_i);
    chk("drain", 0, rq.size());
  endtask
  // foreign master: one word into the bridge window
  task automatic tgt_wr(input logic [31:0] a, d);
    {tb_frame_n, tb_oe, tb_ad, tb_cbe_n} <= {2'b01, a, PBSI_CMD_MEM_WR};
    @(posedge sys_clk_i);
    {tb_frame_n, tb_irdy_n, tb_ad, tb_cbe_n} <= {2'b10, d, 4'h0};
    tq.push_back('{a, d, 4'hF});
    do @(negedge sys_clk_i); while (trdy_n_i !== 1'b0);
    chk("devsel", 1'b0, devsel_n_i);
    @(posedge sys_clk_i);
    {tb_irdy_n, tb_oe} <= 2'b10;
  endtask

  // ------------------------------------------------------------
  // monitor: results against notes, wire phases against rules
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!sys_rst_i) begin
      if (mrsp_valid_o) begin
        chk("mrsp", rq.pop_front(), mrsp_o);
        void'(wq.pop_front());
      end
      if (twr_valid_o) chk("twr", tq.pop_front(), twr_o);
      if (frame_oe_o && !frame_n_o) begin
        chk("addr", wq[0].addr, ad_o);
        chk("cmd", wq[0].cmd, cbe_n_o);
      end
      if (irdy_oe_o && !irdy_n_o && wq[0].write) begin
        chk("wdata", wq[0].data, ad_o);
        chk("lanes", 4'(~wq[0].be), cbe_n_o);
      end
      if (par_oe_o) chk("par", ^{pad, pcbe}, par_o);
      pad <= ad_o;
      pcbe <= cbe_n_i;
      n_fs += foreign_serr_o;
      n_fp += foreign_perr_o;
      n_dp += data_perr_o | serr_oe_o;
    end
  end

  // ------------------------------------------------------------
  // main sequence and verdict
  // ------------------------------------------------------------
  task automatic results;
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    n_errors++;
    results;
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge sys_clk_i);
    d1 = lfsr(32'hfc4e);
    d2 = lfsr(d1);
    mreq(1'b1, 32'h0000_1000, d1, 4'hF, '0);
    mreq(1'b1, 32'h0000_1000, d2, 4'h5, '0);
    mreq(1'b0, 32'h0000_1000, 32'h0, 4'hF,
         '{{d1[31:24], d2[23:16], d1[15:8], d2[7:0]}, 1'b0});
    // nobody claims the bridge window: master gives up after the wait
    mreq(1'b1, 32'h8000_0010, d1, 4'hF, '{32'h0, 1'b1});
    drain;
    // retried once by a slow target, then completes silently
    {retry, slow} <= 2'b11;
    mreq(1'b1, 32'h0000_2000, d2, 4'hF, '0);
    drain;
    {retry, emulation_mode_i, lock_n_i} <= 3'b010;
    @(posedge sys_clk_i);
    tgt_wr(32'h8000_0040, d1);
    wt(3);
    chk("irq", 1'b1, modified_memory_irq_o);
    chk("lock", 1'b1, mem_locked_o);
    @(posedge sys_clk_i);
    {irq_clear_i, lock_n_i} <= 2'b11;
    @(posedge sys_clk_i);
    irq_clear_i <= 1'b0;
    wt(2);
    chk("irq_clr", 1'b0, modified_memory_irq_o);
    chk("unlock", 1'b0, mem_locked_o);
    @(posedge sys_clk_i);
    flush_request_in_i <= 1'b1;
    for (int i = 0; i < 30 && flush_done_ack_o !== 1'b1; i++) wt(1);
    chk("ack", 1'b1, flush_done_ack_o);
    chk("block", 1'b1, cpu_block_o);
    chk("ready", 1'b0, mreq_ready_o);
    wt(4);
    chk("ack_hold", 1'b1, flush_done_ack_o);
    @(posedge sys_clk_i);
    {flush_request_in_i, isa_bus_master_request_i} <= 2'b01;
    {tb_serr_n, tb_perr_n} <= 2'b00;
    @(posedge sys_clk_i);
    {tb_serr_n, tb_perr_n} <= 2'b11;
    wt(7);
    chk("ack_drop", 1'b0, flush_done_ack_o);
    chk("unblock", 1'b0, cpu_block_o);
    chk("isa", 1'b1, isa_mem_req_o);
    chk("serr", 1, n_fs);
    chk("perr", 1, n_fp);
    chk("parity_err", 0, n_dp);
    results;
  end
endmodule // pci_bus_side_interface_tb
